/* File: design/fro_core.sv */
// decoder and executor for complement, increment, decrement, skip and branch
// ----------------------------------------------------------------------
// Operation
// - byte ops write accumulator when destination bit is 0, file register when 1
// - don't-care instruction bits never change behaviour
// - bit field picks one bit position of the addressed 8-bit register
// - one instruction cycle each; branch or true test takes two, second a nop
// - an instruction cycle spans exactly four oscillator periods
// - complement inverts file register, writes destination, updates only zero
// - branch loads 11-bit literal into pc 10:0, no flags changed
// - branch copies upper latch bits 4:3 into pc 12:11, takes two cycles
// - decrement subtracts one, writes destination, updates only zero
// - increment adds one, writes destination, updates only zero
// - decrement-skip stores result, no flags; zero result turns next into nop
// - increment-skip stores result, no flags; zero result turns next into nop
// - instructions decode as 14-bit words of opcode plus operand fields
// - file operand addresses 0x00 through 0x7f
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module fro_core
  import fro_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [INSTR_W-1:0]   instr_word,
  input  wire logic [LATCH_W-1:0]   program_counter_upper_latch,
  output var  logic [PC_W-1:0]      pc,
  output var  logic [DATA_W-1:0]    w_reg,
  output var  logic                 zero_flag,
  output var  logic [1:0]           phase,
  output var  logic                 nop_cycle
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // only the opcode bits are compared, so don't-care bits fall out
  function automatic fro_op_type decode_op(input logic [INSTR_W-1:0] ir);
    fro_op_type op;
    op = FRO_OP_NOP;
    if (ir[OP_BR_LSB +: OP_BR_W] == OPC_BRANCH) begin
      op = FRO_OP_BRANCH;
    end else if (ir[OP_BIT_LSB +: OP_BIT_W] == OPC_BIT_CLEAR) begin
      op = FRO_OP_BIT_CLEAR;
    end else if (ir[OP_BIT_LSB +: OP_BIT_W] == OPC_BIT_SET) begin
      op = FRO_OP_BIT_SET;
    end else begin
      case (ir[OP_BYTE_LSB +: OP_BYTE_W])
        OPC_COMPLEMENT: op = FRO_OP_COMPLEMENT;
        OPC_DECREMENT:  op = FRO_OP_DECREMENT;
        OPC_INCREMENT:  op = FRO_OP_INCREMENT;
        OPC_DEC_SKIP:   op = FRO_OP_DEC_SKIP;
        OPC_INC_SKIP:   op = FRO_OP_INC_SKIP;
        default:        op = FRO_OP_NOP;
      endcase
    end
    return op;
  endfunction

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte ops honour the destination bit; bit ops always go back to the file
  function automatic logic is_byte_op(input fro_op_type op);
    logic hit;
    hit = 1'b0;
    case (op)
      FRO_OP_COMPLEMENT, FRO_OP_DECREMENT, FRO_OP_INCREMENT,
      FRO_OP_DEC_SKIP, FRO_OP_INC_SKIP: hit = 1'b1;
      default:                          hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic is_bit_op(input fro_op_type op);
    return (op == FRO_OP_BIT_CLEAR) || (op == FRO_OP_BIT_SET);
  endfunction

  // one zero test feeds both the flag and the skip decision
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return (v == 8'h00);
  endfunction

  // q3 arithmetic; wraps at 8 bits, so 0xff + 1 is zero for the skip test
  function automatic logic [DATA_W-1:0] alu(input fro_op_type        op,
                                            input logic [DATA_W-1:0] d,
                                            input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] r;
    r = d;
    case (op)
      FRO_OP_COMPLEMENT: r = ~d;
      FRO_OP_DECREMENT,
      FRO_OP_DEC_SKIP:   r = 8'(d - 8'h01);
      FRO_OP_INCREMENT,
      FRO_OP_INC_SKIP:   r = 8'(d + 8'h01);
      FRO_OP_BIT_CLEAR:  r = d & ~mask;
      FRO_OP_BIT_SET:    r = d | mask;
      default:           r = d;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  fro_state_type     s;
  fro_state_type     next_s;
  fro_op_type        op;
  logic [DATA_W-1:0] file_rdata;
  logic              file_we;
  logic [FADDR_W-1:0] faddr;
  logic              dest_file;
  logic [BIT_SEL_W-1:0] bit_sel;
  logic [DATA_W-1:0]  bit_mask;

  assign op        = decode_op(s.ir);
  assign faddr     = s.ir[FADDR_W-1:0];
  assign dest_file = s.ir[DEST_BIT];
  assign bit_sel   = s.ir[BIT_SEL_LSB +: BIT_SEL_W];

  // ----------------------------------------------------------------
  // bit select mask
  // ----------------------------------------------------------------
  // one-hot lanes, so set and clear are a plain or and and-not
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit_mask
    assign bit_mask[i] = (bit_sel == BIT_SEL_W'(i));
  end

  // ----------------------------------------------------------------
  // file write enable
  // ----------------------------------------------------------------
  // write lands in Q4; read was issued from Q1 so data is ready by Q3
  always_comb begin
    file_we = 1'b0;
    if (s.q == PHASE_Q4 && !s.flush) begin
      if (is_bit_op(op)) begin
        file_we = 1'b1;
      end else if (is_byte_op(op)) begin
        file_we = dest_file;
      end
    end
  end

  // ----------------------------------------------------------------
  // file storage
  // ----------------------------------------------------------------
  fro_file_mem #(
    .ADDR_W (FADDR_W),
    .DATA_W (DATA_W)
  ) fro_file_mem_i (
    .mclk  (mclk),
    .we    (file_we),
    .waddr (faddr),
    .wdata (s.result),
    .raddr (faddr),
    .rdata (file_rdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s   = s;
    next_s.q = 2'(s.q + 2'h1);

    if (s.q == PHASE_Q3) begin
      next_s.result = alu(op, file_rdata, bit_mask);
    end

    if (s.q == PHASE_Q4) begin
      // the word fetched at pc enters the register; pc moves on
      next_s.ir    = instr_word;
      next_s.pc    = 13'(s.pc + 13'h0001);
      next_s.flush = 1'b0;
      if (!s.flush) begin
        if (is_byte_op(op) && !dest_file) begin
          next_s.w = s.result;
        end
        case (op)
          FRO_OP_COMPLEMENT, FRO_OP_DECREMENT, FRO_OP_INCREMENT: begin
            next_s.zero = is_zero(s.result);
          end
          FRO_OP_DEC_SKIP, FRO_OP_INC_SKIP: begin
            // skip by discarding the word just fetched
            next_s.flush = is_zero(s.result);
          end
          FRO_OP_BRANCH: begin
            next_s.pc = {program_counter_upper_latch[LATCH_PC_LSB +: 2],
                         s.ir[LIT_W-1:0]};
            next_s.flush = 1'b1;
          end
          default: next_s.flush = 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  // the file array stays out of reset; only the pipeline state clears
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s.q      <= PHASE_Q1;
      s.pc     <= PC_RESET;
      s.ir     <= IR_RESET;
      s.flush  <= 1'b0;
      s.w      <= W_RESET;
      s.zero   <= 1'b0;
      s.result <= W_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign pc        = s.pc;
  assign w_reg     = s.w;
  assign zero_flag = s.zero;
  assign phase     = s.q;
  assign nop_cycle = s.flush;

endmodule // fro_core
`default_nettype wire

/* File: design/fro_file_mem.sv */
// file register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module fro_file_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output var  logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // no reset on the array; contents are undefined until written
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // fro_file_mem
`default_nettype wire

/* File: design/fro_pkg.sv */
// package: constants and types for the file register operation unit
package fro_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int INSTR_W       = 14;
  localparam int DATA_W        = 8;
  localparam int FADDR_W       = 7;
  localparam int PC_W          = 13;
  localparam int LATCH_W       = 5;
  localparam int LIT_W         = 11;
  localparam int DEST_BIT      = 7;
  localparam int BIT_SEL_LSB   = 7;
  localparam int BIT_SEL_W     = 3;
  localparam int OP_BYTE_LSB   = 8;
  localparam int OP_BYTE_W     = 6;
  localparam int OP_BIT_LSB    = 10;
  localparam int OP_BIT_W      = 4;
  localparam int OP_BR_LSB     = 11;
  localparam int OP_BR_W       = 3;
  localparam int LATCH_PC_LSB  = 3;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_COMPLEMENT  = 6'h09;
  localparam logic [5:0] OPC_DECREMENT   = 6'h03;
  localparam logic [5:0] OPC_INCREMENT   = 6'h0a;
  localparam logic [5:0] OPC_DEC_SKIP    = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP    = 6'h0f;
  localparam logic [3:0] OPC_BIT_CLEAR   = 4'h4;
  localparam logic [3:0] OPC_BIT_SET     = 4'h5;
  localparam logic [2:0] OPC_BRANCH      = 3'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OSC_PERIOD_NS    = 100;
  localparam int INSTR_CYCLE_NS   = 400;
  localparam int PHASES_PER_CYCLE = INSTR_CYCLE_NS / OSC_PERIOD_NS;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'(PHASES_PER_CYCLE - 1);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]    PC_RESET = 13'h0000;
  localparam logic [INSTR_W-1:0] IR_RESET = 14'h0000;
  localparam logic [DATA_W-1:0]  W_RESET  = 8'h00;

  typedef enum logic [3:0] {
    FRO_OP_NOP,
    FRO_OP_COMPLEMENT,
    FRO_OP_DECREMENT,
    FRO_OP_INCREMENT,
    FRO_OP_DEC_SKIP,
    FRO_OP_INC_SKIP,
    FRO_OP_BIT_CLEAR,
    FRO_OP_BIT_SET,
    FRO_OP_BRANCH
  } fro_op_type;

  typedef struct packed {
    logic [1:0]         q;
    logic [PC_W-1:0]    pc;
    logic [INSTR_W-1:0] ir;
    logic               flush;
    logic [DATA_W-1:0]  w;
    logic               zero;
    logic [DATA_W-1:0]  result;
  } fro_state_type;

endpackage

/* File: sim/fro_core_monitor.sv */
// assertion checker for the file register operation unit
`timescale 1ns/1ps
`default_nettype none
module fro_core_monitor
  import fro_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [LATCH_W-1:0] program_counter_upper_latch,
  input wire logic [PC_W-1:0]    pc,
  input wire logic [DATA_W-1:0]  w_reg,
  input wire logic               zero_flag,
  input wire logic [1:0]         phase,
  input wire logic               nop_cycle
);
  // ------------------------------------------
  // executing word, seen from the ports
  // ------------------------------------------
  logic [INSTR_W-1:0] ir_seen;
  logic [PC_W-1:0]    br_tgt;
  logic [5:0]         opc;
  logic               ex;
  logic               is_br;
  logic               is_ar;
  logic               is_sk;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ir_seen <= IR_RESET;
    end else if (phase == PHASE_Q4) begin
      ir_seen <= instr_word;
    end
  end
  assign opc    = ir_seen[13:8];
  assign ex     = (phase == PHASE_Q4) && !nop_cycle;
  assign is_br  = ir_seen[13:11] == OPC_BRANCH;
  assign is_ar  = opc == OPC_COMPLEMENT || opc == OPC_DECREMENT || opc == OPC_INCREMENT;
  assign is_sk  = opc == OPC_DEC_SKIP || opc == OPC_INC_SKIP;
  assign br_tgt = {program_counter_upper_latch[4:3], ir_seen[10:0]};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_flush;
    nop_cycle [*4] ##1 !nop_cycle;
  endsequence
  property p_phase;
    1'b1 |=> phase == $past(phase) + 2'h1;
  endproperty
  property p_hold;
    phase != PHASE_Q4 |=> $stable(pc) && $stable(w_reg) && $stable(zero_flag) && $stable(nop_cycle);
  endproperty
  property p_pc_step;
    (phase == PHASE_Q4) && !(ex && is_br) |=> pc == $past(pc) + 13'h1;
  endproperty
  property p_br_tgt;
    ex && is_br |=> pc == $past(br_tgt) && $stable(zero_flag) && $stable(w_reg);
  endproperty
  property p_br_flush;
    ex && is_br |=> s_flush;
  endproperty
  property p_skip;
    ex && is_sk && !ir_seen[DEST_BIT] |=> nop_cycle == (w_reg == 8'h00) && $stable(zero_flag);
  endproperty
  property p_zero;
    ex && is_ar && !ir_seen[DEST_BIT] |=> zero_flag == (w_reg == 8'h00) && !nop_cycle;
  endproperty
  property p_dest_file;
    ex && (is_ar || is_sk) && ir_seen[DEST_BIT] |=> $stable(w_reg);
  endproperty
  a_phase : assert property (p_phase) else $error("phase did not step");
  a_hold : assert property (p_hold) else $error("output moved mid cycle");
  a_pc_step : assert property (p_pc_step) else $error("pc did not advance");
  a_br_tgt : assert property (p_br_tgt) else $error("branch target wrong");
  a_br_flush : assert property (p_br_flush) else $error("branch flush wrong");
  a_skip : assert property (p_skip) else $error("skip wrong");
  a_zero : assert property (p_zero) else $error("zero flag wrong");
  a_dest_file : assert property (p_dest_file) else $error("accumulator written");
endmodule // fro_core_monitor
bind fro_core fro_core_monitor fro_core_monitor_i (.mclk(mclk), .rst_n(rst_n),
  .instr_word(instr_word), .program_counter_upper_latch(program_counter_upper_latch),
  .pc(pc), .w_reg(w_reg), .zero_flag(zero_flag), .phase(phase), .nop_cycle(nop_cycle));
`default_nettype wire

/* File: sim/tb_fro_core.sv */
// self-checking bench for the file register operation unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_fro_core
  import fro_pkg::*;
;
  logic               mclk = 1'b0;
  logic               rst_n = 1'b0;
  logic [INSTR_W-1:0] instr_word = IR_RESET;
  logic [LATCH_W-1:0] latch = 5'h00;
  logic [PC_W-1:0]    pc;
  logic [DATA_W-1:0]  w_reg;
  logic               zero_flag;
  logic [1:0]         phase;
  logic               nop_cycle;
  int                 errors = 0;
  int                 tests_run = 0;
  always #50 mclk = ~mclk;
  fro_core fro_core_i (.mclk(mclk), .rst_n(rst_n), .instr_word(instr_word),
    .program_counter_upper_latch(latch), .pc(pc), .w_reg(w_reg),
    .zero_flag(zero_flag), .phase(phase), .nop_cycle(nop_cycle));
  // ------------------------------------------
  // word feed: one word per instruction cycle
  // ------------------------------------------
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic issue(input logic [INSTR_W-1:0] word);
    do step(); while (phase !== PHASE_Q4);
    instr_word = word;
  endtask
  task automatic run(input logic [INSTR_W-1:0] word);
    issue(word);
    issue(IR_RESET);
    step();
  endtask
  // memory starts unknown, so build values bit by bit
  task automatic set_reg(input logic [6:0] a, input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      issue({v[i] ? OPC_BIT_SET : OPC_BIT_CLEAR, 3'(i), a});
  endtask
  task automatic t_byte();
    logic [5:0] op [6] = '{OPC_COMPLEMENT, OPC_COMPLEMENT, OPC_INCREMENT,
                           OPC_INCREMENT, OPC_DECREMENT, OPC_DECREMENT};
    logic [7:0] v [6] = '{8'h0f, 8'hff, 8'hff, 8'h41, 8'h01, 8'h00};
    logic [7:0] r [6] = '{8'hf0, 8'h00, 8'h00, 8'h42, 8'h00, 8'hff};
    for (int k = 0; k < 6; k++) begin
      set_reg(7'h7f, v[k]);
      run({op[k], 1'b0, 7'h7f});
      `CHK("w_reg", r[k], w_reg)
      `CHK("zero_flag", r[k] == 8'h00, zero_flag)
      `CHK("phase", PHASE_Q1, phase)
    end
    $display("t_byte done");
  endtask
  task automatic t_dest();
    set_reg(7'h05, 8'h33);
    run({OPC_INCREMENT, 1'b1, 7'h05});
    run({OPC_COMPLEMENT, 1'b0, 7'h05});
    `CHK("w_reg", 8'hcb, w_reg)
    $display("t_dest done");
  endtask
  task automatic t_skip();
    logic [5:0] op [3] = '{OPC_DEC_SKIP, OPC_INC_SKIP, OPC_DEC_SKIP};
    logic [7:0] v [3] = '{8'h01, 8'hff, 8'h02};
    logic [7:0] r [3] = '{8'h00, 8'h00, 8'h01};
    for (int k = 0; k < 3; k++) begin
      set_reg(7'h09, v[k]);
      issue({op[k], 1'b0, 7'h09});
      issue({OPC_COMPLEMENT, 1'b0, 7'h09});
      step();
      `CHK("w_reg", r[k], w_reg)
      `CHK("nop_cycle", r[k] == 8'h00, nop_cycle)
      `CHK("zero_flag", 1'b0, zero_flag)
      issue(IR_RESET);
      step();
      `CHK("w_reg", r[k] == 8'h00 ? 8'h00 : ~v[k], w_reg)
    end
    $display("t_skip done");
  endtask
  task automatic t_branch();
    logic [4:0]  l [2] = '{5'h18, 5'h07};
    logic [10:0] lit [2] = '{11'h210, 11'h7ff};
    logic [12:0] t [2] = '{13'h1a10, 13'h07ff};
    for (int k = 0; k < 2; k++) begin
      latch = l[k];
      issue({OPC_BRANCH, lit[k]});
      issue({OPC_COMPLEMENT, 1'b0, 7'h05});
      step();
      `CHK("pc", t[k], pc)
      `CHK("nop_cycle", 1'b1, nop_cycle)
      issue(IR_RESET);
      step();
      `CHK("pc", t[k] + 13'h1, pc)
      `CHK("w_reg", 8'hfd, w_reg)
    end
    $display("t_branch done");
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    step();
    `CHK("pc", PC_RESET, pc)
    `CHK("w_reg", W_RESET, w_reg)
    `CHK("zero_flag", 1'b0, zero_flag)
    `CHK("nop_cycle", 1'b0, nop_cycle)
    `CHK("phase", PHASE_Q1, phase)
    rst_n = 1'b1;
    // three edges after release reach the last phase of the first cycle
    repeat (3) step();
    `CHK("phase", PHASE_Q4, phase)
    instr_word = {OPC_COMPLEMENT, 1'b0, 7'h05};
    issue(IR_RESET);
    step();
    `CHK("w_reg", 8'hcb, w_reg)
    `CHK("pc", PC_RESET + 13'h2, pc)
    $display("t_reset done");
  endtask
  task automatic test_done();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_byte();
    t_dest();
    t_skip();
    t_branch();
    t_reset();
    test_done();
  end
  // whole run is well under a thousand cycles
  initial begin
    #1_000_000;
    errors++;
    test_done();
  end
endmodule // tb_fro_core
`default_nettype wire
